// *** hw/temp_sense_ctrl.sv ***
// Behaviour
// - compare pin ratio against hot, cold thresholds
// - bias strobe on for 24 ms each cycle
// - deglitch hot and cold while strobe high
// - strobe drops, pin released after bias window
// - monitor control-high 35 or 235 ms
// - high pin in window sets control-detect flag
// - pin at ground: shut down, code 0x03
// - pin at battery: shut down, code 0x00
// - die hot: regulator off, code 0x02, hysteresis
// - report received power including losses
// - average power over announced window
// - report exceeds reference by 1 to 374 mW
// - start-up, transfer, termination on three causes
// - 11-bit LSB-first frames, odd parity
// - 0.5 ms bi-phase bits, ones toggle twice
module tsc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] m_q;
  // two stages, first stage read only by second
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      m_q <= '0;
      q   <= '0;
    end
    else
    begin
      m_q <= d;
      q   <= m_q;
    end
  end
endmodule : tsc_sync2

module tsc_deglitch #(
  parameter int N = 2
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic en,
  input  wire logic d,
  output logic      q
);
  localparam int CW = $clog2(N + 1);
  logic [CW-1:0] cnt_q;
  // result only moves after N stable samples under bias
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q <= '0;
      q     <= 1'b0;
    end
    else if (!en || d == q)
      cnt_q <= '0;
    else if (cnt_q == CW'(N - 1))
    begin
      q     <= d;
      cnt_q <= '0;
    end
    else
      cnt_q <= cnt_q + 1'b1;
  end
endmodule : tsc_deglitch

module temp_sense_ctrl #(
  parameter int BIAS_N = tsc_pkg::BIAS_CYC,
  parameter int PRI_N  = tsc_pkg::PRI_CYC,
  parameter int STD_N  = tsc_pkg::STD_CYC,
  parameter int DEG_N  = tsc_pkg::DEG_CYC,
  parameter int HALF_N = tsc_pkg::HALF_CYC
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  // axi4-lite slave
  input  wire logic [tsc_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [tsc_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // asynchronous analog and link status
  input  wire tsc_pkg::cmp_t               cmp_in,
  input  wire logic                        die_hot_in,
  input  wire logic                        die_cool_in,
  input  wire logic                        rx_present_in,
  input  wire logic                        tx_power_in,
  // power samples, same clock
  input  wire logic                        pwr_valid,
  input  wire logic [15:0]                 pwr_out_mw,
  input  wire logic [15:0]                 pwr_loss_mw,
  // device outputs
  output logic                             temp_bias_strobe,
  output logic                             ldo_en,
  output logic                             comm_mod,
  output logic                             irq
);
  import tsc_pkg::*;
  localparam int TW = $clog2(STD_N + 1);
  localparam int HW = $clog2(HALF_N + 1);

  logic [6:0] sync_s;
  cmp_t       cmp_s;
  logic       die_hot_s, die_cool_s, present_s, txok_s;
  tsc_sync2 #(.W(7)) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       ({cmp_in, die_hot_in, die_cool_in, rx_present_in, tx_power_in}),
    .q       (sync_s)
  );
  assign cmp_s = sync_s[6:4];
  assign {die_hot_s, die_cool_s, present_s, txok_s} = sync_s[3:0];

  // bus slave state
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, wdata_q, rd_d;
  logic [3:0] wstrb_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic wr_fire;
  logic [31:0] wmask;
  assign wr_fire = !awready_q && !wready_q && !bvalid_q;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // software registers
  logic [1:0] ctrl_q;
  logic [EV_W-1:0] istat_q, imask_q, ev;
  logic [2:0] win_q;
  logic [8:0] ofs_q;
  logic [15:0] power_q;

  // block state
  meas_t meas_q;
  mode_t mode_q;
  logic [TW-1:0] tmr_q;
  logic strobe_q, prio_q, ctrl_det_q, die_sd_q, die_sent_q, mon_start;
  logic hot_q, cold_q, ldo_q, irq_q;
  logic [2:0] prev_q;

  // message serializer state, declared early: status read shows busy
  logic busy_q, ph_q, comm_q, msg_go, cur_bit, last_half;
  logic [1:0] byte_q;
  logic [3:0] bit_q;
  logic [HW-1:0] hc_q;
  logic [7:0] code_q, code_sel, msg_byte;

  // address phase and data phase taken in either order
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end
    else
    begin
      if (s_axi_awvalid && awready_q)
      begin
        awaddr_q  <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q)
      begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        wready_q <= 1'b0;
      end
      if (wr_fire)
      begin
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
        bvalid_q  <= 1'b1;
        bresp_q   <= (awaddr_q > PCFG_OFS || awaddr_q[1:0] != 2'h0) ? RESP_SLV : RESP_OKAY;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // read mux, unmapped reads zero
  always_comb
  begin
    rd_d = '0;
    unique case (s_axi_araddr)
      CTRL_OFS:   rd_d[1:0] = ctrl_q;
      STATUS_OFS: rd_d[$bits(status_t)-1:0] = {mode_q, busy_q, die_sd_q, ctrl_det_q, cold_q, hot_q};
      ISTAT_OFS:  rd_d[EV_W-1:0] = istat_q;
      IMASK_OFS:  rd_d[EV_W-1:0] = imask_q;
      POWER_OFS:  rd_d[15:0] = power_q;
      PCFG_OFS:   rd_d = {7'h00, ofs_q, 13'h0000, win_q};
      default:    rd_d = '0;
    endcase
  end

  // one read at a time, answered one cycle after address
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_d;
      rresp_q   <= (s_axi_araddr > PCFG_OFS || s_axi_araddr[1:0] != 2'h0) ? RESP_SLV : RESP_OKAY;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // writable registers with byte strobes
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_q  <= CTRL_RST;
      imask_q <= '0;
      win_q   <= WIN_RST;
      ofs_q   <= OFS_RST;
    end
    else if (wr_fire)
    begin
      unique case (awaddr_q)
        CTRL_OFS:  ctrl_q <= (ctrl_q & ~wmask[1:0]) | (wdata_q[1:0] & wmask[1:0]);
        IMASK_OFS: imask_q <= (imask_q & ~wmask[EV_W-1:0]) | (wdata_q[EV_W-1:0] & wmask[EV_W-1:0]);
        PCFG_OFS:
        begin
          if (wstrb_q[0])
            win_q <= wdata_q[PCFG_WIN_LSB +: 3];
          if (wstrb_q[2] && wstrb_q[3])
            ofs_q <= wdata_q[PCFG_OFS_LSB +: 9];
        end
        default: ;
      endcase
    end
  end

  // bias then release, endlessly while enabled
  assign mon_start = ctrl_q[CTRL_EN_BIT] && tmr_q == '0 && meas_q == MEAS_BIAS && strobe_q;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meas_q   <= MEAS_BIAS;
      tmr_q    <= '0;
      strobe_q <= 1'b0;
      prio_q   <= 1'b0;
    end
    else if (!ctrl_q[CTRL_EN_BIT])
    begin
      meas_q   <= MEAS_BIAS;
      tmr_q    <= '0;
      strobe_q <= 1'b0;
    end
    else if (tmr_q != '0)
      tmr_q <= tmr_q - 1'b1;
    else
    begin
      unique case (meas_q)
        MEAS_BIAS:
          if (!strobe_q)
          begin
            strobe_q <= 1'b1;
            tmr_q    <= TW'(BIAS_N - 1);
          end
          else
          begin
            strobe_q <= 1'b0;
            meas_q   <= MEAS_MON;
            prio_q   <= ctrl_q[CTRL_PRIO_BIT];
            tmr_q    <= ctrl_q[CTRL_PRIO_BIT] ? TW'(PRI_N - 1) : TW'(STD_N - 1);
          end
        MEAS_MON:
        begin
          meas_q   <= MEAS_BIAS;
          strobe_q <= 1'b1;
          tmr_q    <= TW'(BIAS_N - 1);
        end
      endcase
    end
  end

  // ratiometric comparators, filtered only under bias
  tsc_deglitch #(.N(DEG_N)) u_hot (
    .clk     (clk),
    .reset_n (reset_n),
    .en      (strobe_q),
    .d       (cmp_s.hot),
    .q       (hot_q)
  );
  tsc_deglitch #(.N(DEG_N)) u_cold (
    .clk     (clk),
    .reset_n (reset_n),
    .en      (strobe_q),
    .d       (cmp_s.cold),
    .q       (cold_q)
  );

  // external drive seen while pin floats; set beats clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_det_q <= 1'b0;
    else if (meas_q == MEAS_MON && !strobe_q && cmp_s.ctrl_hi)
      ctrl_det_q <= 1'b1;
    else if (mon_start)
      ctrl_det_q <= 1'b0;
  end

  // die shutdown with hysteresis release
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      die_sd_q <= 1'b0;
    else if (die_hot_s)
      die_sd_q <= 1'b1;
    else if (die_cool_s)
      die_sd_q <= 1'b0;
  end

  // die fault outranks a host request: it must be reported even mid-fault
  assign msg_go = mode_q == MODE_XFER && !busy_q && ((die_sd_q && !die_sent_q) || hot_q || ctrl_det_q);
  assign code_sel = (die_sd_q && !die_sent_q) ? CODE_INT_FAULT : hot_q ? CODE_OVER_TEMP : CODE_UNKNOWN;
  assign msg_byte = byte_q == 2'h0 ? MSG_HDR : byte_q == 2'h1 ? code_q : MSG_HDR ^ code_q;
  assign last_half = busy_q && hc_q == '0 && ph_q;

  // frame: start 0, data lsb first, odd parity, stop 1
  always_comb
  begin
    cur_bit = 1'b1;
    if (bit_q == 4'h0)
      cur_bit = 1'b0;
    else if (bit_q <= 4'h8)
      cur_bit = msg_byte[3'(bit_q - 4'h1)];
    else if (bit_q == 4'h9)
      cur_bit = ~^msg_byte;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      die_sent_q <= 1'b0;
    else if (!die_sd_q)
      die_sent_q <= 1'b0;
    else if (msg_go && code_sel == CODE_INT_FAULT)
      die_sent_q <= 1'b1;
  end

  // bi-phase: edge at every bit start, extra mid-bit edge for a one
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy_q <= 1'b0;
      ph_q   <= 1'b0;
      comm_q <= 1'b0;
      byte_q <= '0;
      bit_q  <= '0;
      hc_q   <= '0;
      code_q <= '0;
    end
    else if (!busy_q)
    begin
      if (msg_go)
      begin
        busy_q <= 1'b1;
        code_q <= code_sel;
        byte_q <= '0;
        bit_q  <= '0;
        ph_q   <= 1'b0;
        hc_q   <= HW'(HALF_N - 1);
        comm_q <= ~comm_q;
      end
    end
    else if (hc_q != '0)
      hc_q <= hc_q - 1'b1;
    else
    begin
      hc_q <= HW'(HALF_N - 1);
      ph_q <= ~ph_q;
      if (!ph_q)
      begin
        if (cur_bit)
          comm_q <= ~comm_q;
      end
      else if (bit_q != 4'(FRAME_BITS - 1))
      begin
        bit_q  <= bit_q + 1'b1;
        comm_q <= ~comm_q;
      end
      else if (byte_q != 2'(MSG_BYTES - 1))
      begin
        bit_q  <= '0;
        byte_q <= byte_q + 1'b1;
        comm_q <= ~comm_q;
      end
      else
        busy_q <= 1'b0;
    end
  end

  // top-level modes
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      mode_q <= MODE_START;
    else
    begin
      unique case (mode_q)
        MODE_START:
          if (present_s && txok_s)
            mode_q <= MODE_XFER;
        MODE_XFER:
          if (!present_s || !txok_s || (msg_go && code_sel != CODE_INT_FAULT))
            mode_q <= MODE_TERM;
        MODE_TERM:
          if (!txok_s)
            mode_q <= MODE_START;
      endcase
    end
  end

  // regulator off outside transfer and during die fault
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ldo_q <= 1'b0;
    else
      ldo_q <= mode_q == MODE_XFER && !die_sd_q;
  end

  // received power: mean of output plus losses over 2^win samples
  logic [23:0] acc_q, sum_w, avg_w, rep_w;
  logic [7:0] cnt_q;
  logic [8:0] ofs_eff;
  assign ofs_eff = ofs_q < OFS_MIN ? OFS_MIN : (ofs_q > OFS_MAX ? OFS_MAX : ofs_q);
  assign sum_w = acc_q + 24'(pwr_out_mw) + 24'(pwr_loss_mw);
  assign avg_w = sum_w >> win_q;
  assign rep_w = avg_w + 24'(ofs_eff);
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_q   <= '0;
      cnt_q   <= '0;
      power_q <= '0;
    end
    else if (pwr_valid)
    begin
      if (cnt_q == 8'((1 << win_q) - 1))
      begin
        acc_q   <= '0;
        cnt_q   <= '0;
        power_q <= rep_w > 24'h00FFFF ? 16'hFFFF : rep_w[15:0];
      end
      else
      begin
        acc_q <= sum_w;
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // sticky events, write one to clear, new event wins
  always_comb
  begin
    ev = '0;
    ev[EV_CTRL] = ctrl_det_q & ~prev_q[0];
    ev[EV_HOT]  = hot_q & ~prev_q[1];
    ev[EV_COLD] = cold_q & ~prev_q[2];
    ev[EV_DIE]  = msg_go && code_sel == CODE_INT_FAULT;
    ev[EV_DONE] = last_half && bit_q == 4'(FRAME_BITS - 1) && byte_q == 2'(MSG_BYTES - 1);
    ev[EV_TERM] = mode_q == MODE_XFER && (!present_s || !txok_s || (msg_go && code_sel != CODE_INT_FAULT));
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prev_q  <= '0;
      istat_q <= '0;
      irq_q   <= 1'b0;
    end
    else
    begin
      prev_q  <= {cold_q, hot_q, ctrl_det_q};
      istat_q <= (wr_fire && awaddr_q == ISTAT_OFS) ? (istat_q & ~(wdata_q[EV_W-1:0] & wmask[EV_W-1:0])) | ev
                                                    : istat_q | ev;
      irq_q   <= |(istat_q & imask_q);
    end
  end

  assign s_axi_awready    = awready_q;
  assign s_axi_wready     = wready_q;
  assign s_axi_bvalid     = bvalid_q;
  assign s_axi_bresp      = bresp_q;
  assign s_axi_arready    = arready_q;
  assign s_axi_rvalid     = rvalid_q;
  assign s_axi_rdata      = rdata_q;
  assign s_axi_rresp      = rresp_q;
  assign temp_bias_strobe = strobe_q;
  assign ldo_en           = ldo_q;
  assign comm_mod         = comm_q;
  assign irq              = irq_q;

  // checking helpers: run lengths and edge spacing
  logic [TW-1:0] bias_run_q, mon_run_q;
  logic [HW+1:0] gap_q;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bias_run_q <= '0;
      mon_run_q  <= '0;
      gap_q      <= '0;
    end
    else
    begin
      bias_run_q <= strobe_q ? bias_run_q + 1'b1 : '0;
      mon_run_q  <= meas_q == MEAS_MON ? mon_run_q + 1'b1 : '0;
      gap_q      <= $changed(comm_q) ? (HW+2)'(1) : gap_q + 1'b1;
    end
  end

  sequence s_bias_end;
    $fell(strobe_q) ##0 ctrl_q[CTRL_EN_BIT];
  endsequence
  sequence s_mon_end;
    $rose(strobe_q) ##0 $past(meas_q) == MEAS_MON;
  endsequence
  property p_bias_len;
    @(posedge clk) disable iff (!reset_n) s_bias_end |-> bias_run_q == TW'(BIAS_N);
  endproperty
  a_bias_len: assert property (p_bias_len) else $error("bias strobe length wrong");
  property p_release;
    @(posedge clk) disable iff (!reset_n) s_bias_end |-> meas_q == MEAS_MON ##1 !strobe_q;
  endproperty
  a_release: assert property (p_release) else $error("pin not released after bias");
  property p_mon_len;
    @(posedge clk) disable iff (!reset_n) s_mon_end |-> mon_run_q == (prio_q ? TW'(PRI_N) : TW'(STD_N));
  endproperty
  a_mon_len: assert property (p_mon_len) else $error("monitor window length wrong");
  property p_detect;
    @(posedge clk) disable iff (!reset_n) meas_q == MEAS_MON && !strobe_q && cmp_s.ctrl_hi |=> ctrl_det_q;
  endproperty
  a_detect: assert property (p_detect) else $error("control drive not flagged");
  property p_filter_gate;
    @(posedge clk) disable iff (!reset_n) $changed(hot_q) || $changed(cold_q) |-> $past(strobe_q);
  endproperty
  a_filter_gate: assert property (p_filter_gate) else $error("temperature moved without bias");
  property p_hot_stop;
    @(posedge clk) disable iff (!reset_n) mode_q == MODE_XFER && hot_q && !busy_q && !die_sd_q
      |=> mode_q == MODE_TERM ##0 busy_q;
  endproperty
  a_hot_stop: assert property (p_hot_stop) else $error("hot pin did not end transfer");
  property p_host_stop;
    @(posedge clk) disable iff (!reset_n) mode_q == MODE_XFER && ctrl_det_q && !hot_q && !busy_q && !die_sd_q
      |=> mode_q == MODE_TERM ##0 code_q == CODE_UNKNOWN;
  endproperty
  a_host_stop: assert property (p_host_stop) else $error("host drive did not end transfer");
  property p_die_off;
    @(posedge clk) disable iff (!reset_n) die_sd_q |=> !ldo_en;
  endproperty
  a_die_off: assert property (p_die_off) else $error("regulator on during die fault");
  property p_edge_gap;
    @(posedge clk) disable iff (!reset_n) $changed(comm_q) && $past(busy_q) |-> gap_q == (HW+2)'(HALF_N)
      || gap_q == (HW+2)'(2 * HALF_N);
  endproperty
  a_edge_gap: assert property (p_edge_gap) else $error("bit edge spacing wrong");
  property p_ofs_range;
    @(posedge clk) disable iff (!reset_n) ofs_eff >= OFS_MIN && ofs_eff <= OFS_MAX;
  endproperty
  a_ofs_range: assert property (p_ofs_range) else $error("power bias out of range");
  property p_mode_seq;
    @(posedge clk) disable iff (!reset_n) mode_q == MODE_START |=> mode_q != MODE_TERM;
  endproperty
  a_mode_seq: assert property (p_mode_seq) else $error("termination skipped transfer");
endmodule : temp_sense_ctrl

// *** hw/tsc_pkg.sv ***
package tsc_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] ISTAT_OFS  = 8'h08;
  localparam logic [7:0] IMASK_OFS  = 8'h0C;
  localparam logic [7:0] POWER_OFS  = 8'h10;
  localparam logic [7:0] PCFG_OFS   = 8'h14;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;
  // control fields
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_PRIO_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  // event bits, shared by status and mask
  localparam int EV_CTRL = 0;
  localparam int EV_HOT  = 1;
  localparam int EV_COLD = 2;
  localparam int EV_DIE  = 3;
  localparam int EV_DONE = 4;
  localparam int EV_TERM = 5;
  localparam int EV_W    = 6;
  // power config fields
  localparam int PCFG_WIN_LSB = 0;
  localparam int PCFG_OFS_LSB = 16;
  localparam logic [2:0] WIN_RST = 3'h3;
  localparam logic [8:0] OFS_RST = 9'h0BB;
  localparam logic [8:0] OFS_MIN = 9'h001;
  localparam logic [8:0] OFS_MAX = 9'h176;
  // timing
  localparam int CLK_HZ      = 50_000_000;
  localparam int BIAS_MS     = 24;
  localparam int PRI_MS      = 35;
  localparam int STD_MS      = 235;
  localparam int DEGLITCH_MS = 10;
  localparam int BIT_US      = 500;
  localparam int BIAS_CYC    = BIAS_MS * (CLK_HZ / 1000);
  localparam int PRI_CYC     = PRI_MS * (CLK_HZ / 1000);
  localparam int STD_CYC     = STD_MS * (CLK_HZ / 1000);
  localparam int DEG_CYC     = DEGLITCH_MS * (CLK_HZ / 1000);
  localparam int HALF_CYC    = BIT_US * (CLK_HZ / 1_000_000) / 2;
  // end-of-transfer message
  localparam logic [7:0] MSG_HDR        = 8'h02;
  localparam logic [7:0] CODE_UNKNOWN   = 8'h00;
  localparam logic [7:0] CODE_INT_FAULT = 8'h02;
  localparam logic [7:0] CODE_OVER_TEMP = 8'h03;
  localparam int FRAME_BITS = 11;
  localparam int MSG_BYTES  = 3;
  typedef struct packed {
    logic ctrl_hi;
    logic cold;
    logic hot;
  } cmp_t;
  typedef enum logic [1:0] {MODE_START, MODE_XFER, MODE_TERM} mode_t;
  typedef enum logic {MEAS_BIAS, MEAS_MON} meas_t;
  typedef struct packed {
    mode_t mode;
    logic  busy;
    logic  die_sd;
    logic  ctrl_det;
    logic  cold;
    logic  hot;
  } status_t;
endpackage : tsc_pkg

// *** testbench/temp_sense_ctrl_bench.sv ***
module temp_sense_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import tsc_pkg::*;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, clk, reset_n, pwr_valid;
  logic        die_hot_in, die_cool_in, rx_present_in, tx_power_in, term, fault, comm_q;
  logic        temp_bias_strobe, ldo_en, comm_mod, irq;
  logic [15:0] pwr_out_mw, pwr_loss_mw;
  logic [6:0]  ntc_pct;
  cmp_t        cmp_in;
  int          errors, checks, tog;

  // short counts keep each measurement cycle at 100 clocks, 70 with priority
  temp_sense_ctrl #(.BIAS_N(40), .PRI_N(30), .STD_N(60), .DEG_N(4), .HALF_N(4)) u_temp_sense_ctrl (
    .clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cmp_in, .die_hot_in, .die_cool_in, .rx_present_in, .tx_power_in, .pwr_valid, .pwr_out_mw,
    .pwr_loss_mw, .temp_bias_strobe, .ldo_en, .comm_mod, .irq
  );
  tsc_partner u_tsc_partner (.strobe(temp_bias_strobe), .term, .fault, .ntc_pct, .cmp_in);

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // modulator edges, counted to size each message
  always @(posedge clk)
  begin
    comm_q <= comm_mod;
    if (comm_q !== comm_mod) tog <= tog + 1;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic tally_and_finish();
    if (errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50 && !s_axi_bvalid; i++)
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (i == 50) errors++;
    if (i == 50) tally_and_finish();
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    int i;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50 && !s_axi_rvalid; i++)
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (i == 50) errors++;
    if (i == 50) tally_and_finish();
  endtask : rdr

  // bounded poll of one register bit
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    for (int i = 0; i < 200; i++)
    begin
      rdr(a);
      if (rd[b] === v) break;
    end
    cmp(rd[b], v);
  endtask : poll

  task automatic hold(input logic v, output int n);
    n = 0;
    while (temp_bias_strobe === v && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 2000) errors++;
    if (n == 2000) tally_and_finish();
  endtask : hold

  task automatic t_window(input int lo);
    int n;
    hold(1'b1, n);
    hold(1'b0, n);
    hold(1'b1, n);
    cmp(n, 40);
    hold(1'b0, n);
    cmp(n, lo);
  endtask : t_window

  task automatic pulse(input logic [15:0] o, input logic [15:0] l);
    @(posedge clk);
    pwr_valid <= 1'b1;
    pwr_out_mw <= o;
    pwr_loss_mw <= l;
    @(posedge clk);
    pwr_valid <= 1'b0;
  endtask : pulse

  task automatic t_power();
    wr(PCFG_OFS, 32'h0005_0001);
    pulse(16'h0064, 16'h0014);
    pulse(16'h00C8, 16'h0028);
    rdr(POWER_OFS);
    cmp(rd, 32'h0000_00B9);
    wr(PCFG_OFS, 32'h0000_0001);
    pulse(16'h0064, 16'h0014);
    pulse(16'h0064, 16'h0014);
    rdr(POWER_OFS);
    cmp(rd, 32'h0000_0079);
  endtask : t_power

  task automatic t_ntc();
    ntc_pct <= 7'h10;
    poll(STATUS_OFS, 0, 1'b1);
    ntc_pct <= 7'h40;
    poll(STATUS_OFS, 1, 1'b1);
    poll(STATUS_OFS, 0, 1'b0);
    ntc_pct <= 7'h28;
    poll(STATUS_OFS, 1, 1'b0);
  endtask : t_ntc

  task automatic t_die();
    int t0;
    t0 = tog;
    die_hot_in <= 1'b1;
    die_cool_in <= 1'b0;
    poll(STATUS_OFS, 3, 1'b1);
    cmp(ldo_en, 1'b0);
    poll(ISTAT_OFS, EV_DONE, 1'b1);
    // 33 bit starts plus one mid-bit edge for each of 6 ones
    cmp(tog - t0, 39);
    die_hot_in <= 1'b0;
    die_cool_in <= 1'b1;
    poll(STATUS_OFS, 3, 1'b0);
    cmp(ldo_en, 1'b1);
    wr(ISTAT_OFS, 32'h0000_003F);
  endtask : t_die

  // host request through the three-state driver; n is the expected edge count
  task automatic t_host(input logic t, input logic f, input int n);
    int t0;
    poll(STATUS_OFS, 5, 1'b1);
    wr(IMASK_OFS, 32'h0000_0020);
    t0 = tog;
    term <= t;
    fault <= f;
    poll(STATUS_OFS, 6, 1'b1);
    cmp({rd[2], rd[0]}, {~f, f});
    cmp(irq, 1'b1);
    poll(ISTAT_OFS, EV_DONE, 1'b1);
    cmp(tog - t0, n);
    wr(IMASK_OFS, 32'h0000_0000);
    @(negedge clk);
    cmp(irq, 1'b0);
    wr(ISTAT_OFS, 32'h0000_003F);
    term <= 1'b1;
    fault <= 1'b0;
    tx_power_in <= 1'b0;
    poll(STATUS_OFS, 6, 1'b0);
    // a stale detect flag would end the next transfer at once
    poll(STATUS_OFS, 2, 1'b0);
    tx_power_in <= 1'b1;
  endtask : t_host

  initial
  begin
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, pwr_valid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pwr_out_mw, pwr_loss_mw, errors, checks, tog} = '0;
    {die_hot_in, rx_present_in, tx_power_in, fault, comm_q} = '0;
    {die_cool_in, term} = 2'h3;
    s_axi_wstrb = 4'hF;
    ntc_pct = 7'h28;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rdr(CTRL_OFS);
    cmp(rd, 32'h0000_0001);
    rdr(8'h18);
    cmp(rs, RESP_SLV);
    t_window(60);
    wr(CTRL_OFS, 32'h0000_0003);
    t_window(30);
    t_ntc();
    t_power();
    rx_present_in <= 1'b1;
    tx_power_in <= 1'b1;
    t_die();
    t_host(1'b0, 1'b0, 39);
    t_host(1'b1, 1'b1, 41);
    tally_and_finish();
  end
endmodule : temp_sense_ctrl_bench

// *** testbench/tsc_partner.sv ***
module tsc_partner (
  // host driver and bias strobe
  input  wire logic       strobe,
  input  wire logic       term,
  input  wire logic       fault,
  input  wire logic [6:0] ntc_pct,
  // comparator view of the pin
  output tsc_pkg::cmp_t   cmp_in
);
  timeunit 1ns;
  timeprecision 1ns;
  import tsc_pkg::*;
  logic [6:0] pct;
  // pin level in percent of bias; a released pin sinks through the divider
  assign pct = (term && fault) ? 7'h00 : (!term && !fault) ? 7'h64 : strobe ? ntc_pct : 7'h00;
  // arbitrary thresholds, ordered hot < cold < control-high
  assign cmp_in = '{ctrl_hi: pct > 7'h50, cold: pct > 7'h3A, hot: pct < 7'h14};
endmodule : tsc_partner
